// file: branch_and_trap_decode.sv
// Decoder and executor of the forced trap, conditional jump and bit-clear jump
module branch_and_trap_decode
    import branch_trap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             busy
);
    import branch_trap_pkg::*;

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        exec_state_e state;
        op_kind_e    kind;
        logic [7:0]  cnt;
        logic [23:0] instr;
        logic [23:0] ext;
        logic [23:0] statusWord;
        logic [15:0] pc;
        logic [15:0] retPc;
        logic [23:0] operand;
        logic [15:0] loopEnd;
        logic [15:0] loopCounter;
        logic [15:0] areg;
        logic [15:0] nreg;
        logic [15:0] opAddr;
        logic        taken;
        logic        repeatOn;
        logic        trapPend;
        logic        loopIntr;
        logic        trapCount;
        logic        awGot;
        logic        wGot;
        logic [7:0]  awAddr;
        logic [31:0] wData;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;

    // ************************************************
    // Functions
    // ************************************************
    function automatic logic cond_true(input logic [3:0] cc, input logic [23:0] sw);
        logic base;
        logic nv;
        base = 1'b0;
        nv   = sw[SW_N] ^ sw[SW_V];
        unique case (cc[2:0])
            3'h0: base = ~sw[SW_C];
            3'h1: base = ~nv;
            3'h2: base = ~sw[SW_Z];
            3'h3: base = ~sw[SW_N];
            3'h4: base = ~(sw[SW_Z] | (~sw[SW_U] & ~sw[SW_E]));
            3'h5: base = ~sw[SW_E];
            3'h6: base = ~sw[SW_L];
            3'h7: base = ~(sw[SW_Z] | nv);
        endcase
        return cc[3] ? ~base : base;
    endfunction

    // Effective address and post-update of the address register
    function automatic logic [31:0] ea_calc(input logic [5:0] ea, input logic [15:0] r,
                                            input logic [15:0] n, input logic [15:0] extw);
        logic [15:0] addr;
        logic [15:0] upd;
        addr = r;
        upd  = r;
        if (ea == EA_ABSOLUTE) begin
            addr = extw;
        end else begin
            unique case (ea[5:3])
                EA_POSTDEC_N: upd = r - n;
                EA_POSTINC_N: upd = r + n;
                EA_POSTDEC:   upd = r - 16'h0001;
                EA_POSTINC:   upd = r + 16'h0001;
                EA_INDEXED:   addr = r + n;
                EA_PREDEC: begin
                    addr = r - 16'h0001;
                    upd  = addr;
                end
                default:      upd = r;
            endcase
        end
        return {addr, upd};
    endfunction

    // ************************************************
    // Next state
    // ************************************************
    logic [31:0] eaRes;
    logic        cjShort;
    logic        cjEa;
    logic        bjForm;
    logic        eaExt;
    logic [7:0]  budget;
    logic [15:0] bjAddr;

    always_comb begin
        cur_nxt = cur_r;
        eaRes   = ea_calc(cur_r.instr[13:8], cur_r.areg, cur_r.nreg, cur_r.ext[15:0]);
        cjShort = cur_r.instr[23:20] == OPC_CJ_SHORT_HI;
        cjEa    = cur_r.instr[23:16] == OPC_CJ_EA_HI && cur_r.instr[15:14] == 2'h3
                  && cur_r.instr[7:4] == 4'hA;
        bjForm  = cur_r.instr[23:16] == OPC_BJ_HI && cur_r.instr[7] == 1'b1
                  && cur_r.instr[5] == 1'b0 && !cjEa;
        eaExt   = cjEa && cur_r.instr[13:8] == EA_ABSOLUTE;
        budget  = 8'(CJUMP_CYCLES);
        bjAddr  = eaRes[31:16];
        unique case (cur_r.instr[15:14])
            BJ_AA_SEL: bjAddr = {10'h000, cur_r.instr[13:8]};
            BJ_PP_SEL: bjAddr = PERIPH_BASE | {10'h000, cur_r.instr[13:8]};
            default:   bjAddr = eaRes[31:16];
        endcase

        // AXI write
        if (s_axi_awvalid && !cur_r.awGot) begin
            cur_nxt.awGot  = 1'b1;
            cur_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur_r.wGot) begin
            cur_nxt.wGot  = 1'b1;
            cur_nxt.wData = s_axi_wdata;
        end
        if (cur_r.awGot && cur_r.wGot && !cur_r.bValid) begin
            cur_nxt.awGot  = 1'b0;
            cur_nxt.wGot   = 1'b0;
            cur_nxt.bValid = 1'b1;
            cur_nxt.bResp  = RESP_OKAY;
            unique case (cur_r.awAddr)
                ADDR_CTRL: begin
                    cur_nxt.repeatOn = cur_r.wData[1];
                    cur_nxt.loopIntr = cur_r.wData[2];
                    if (cur_r.wData[0] && cur_r.state == ST_IDLE) begin
                        cur_nxt.state    = ST_EXEC;
                        cur_nxt.cnt      = 8'h00;
                        cur_nxt.trapPend = 1'b0;
                    end
                end
                ADDR_INSTR:   cur_nxt.instr       = cur_r.wData[23:0];
                ADDR_EXT:     cur_nxt.ext         = cur_r.wData[23:0];
                ADDR_STATUS:  cur_nxt.statusWord  = cur_r.wData[23:0];
                ADDR_PC:      cur_nxt.pc          = cur_r.wData[15:0];
                ADDR_OPERAND: cur_nxt.operand     = cur_r.wData[23:0];
                ADDR_LOOP: begin
                    cur_nxt.loopEnd     = cur_r.wData[15:0];
                    cur_nxt.loopCounter = cur_r.wData[31:16];
                end
                ADDR_AREG: begin
                    cur_nxt.areg = cur_r.wData[15:0];
                    cur_nxt.nreg = cur_r.wData[31:16];
                end
                default:      cur_nxt.bResp = RESP_SLVERR;
            endcase
        end
        if (cur_r.bValid && s_axi_bready) begin
            cur_nxt.bValid = 1'b0;
        end

        // AXI read
        if (s_axi_arvalid && !cur_r.rValid) begin
            cur_nxt.rValid = 1'b1;
            cur_nxt.rResp  = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL:    cur_nxt.rData = {29'h0, cur_r.loopIntr, cur_r.repeatOn,
                                               cur_r.state != ST_IDLE};
                ADDR_INSTR:   cur_nxt.rData = {8'h00, cur_r.instr};
                ADDR_EXT:     cur_nxt.rData = {8'h00, cur_r.ext};
                ADDR_STATUS:  cur_nxt.rData = {8'h00, cur_r.statusWord};
                ADDR_PC:      cur_nxt.rData = {16'h0000, cur_r.pc};
                ADDR_OPERAND: cur_nxt.rData = {8'h00, cur_r.operand};
                ADDR_LOOP:    cur_nxt.rData = {cur_r.loopCounter, cur_r.loopEnd};
                ADDR_RESULT:  cur_nxt.rData = {cur_r.retPc, 12'h000, cur_r.trapPend,
                                               cur_r.taken, cur_r.kind};
                ADDR_AREG:    cur_nxt.rData = {cur_r.nreg, cur_r.areg};
                ADDR_OPADDR:  cur_nxt.rData = {16'h0000, cur_r.opAddr};
                default: begin
                    cur_nxt.rData = 32'h00000000;
                    cur_nxt.rResp = RESP_SLVERR;
                end
            endcase
        end
        if (cur_r.rValid && s_axi_rready) begin
            cur_nxt.rValid = 1'b0;
        end

        // Execution sequencer
        unique case (cur_r.state)
            ST_IDLE: ;
            ST_EXEC: begin
                if (cur_r.cnt == 8'h00) begin
                    cur_nxt.taken = 1'b0;
                    if (cur_r.instr == OPC_TRAP) begin
                        cur_nxt.kind = OP_TRAP;
                        cur_nxt.state = ST_TRAP;
                    end else if (cjShort || cjEa) begin
                        cur_nxt.kind = OP_CJ;
                    end else if (bjForm) begin
                        cur_nxt.kind = OP_BJ;
                    end else begin
                        cur_nxt.kind = OP_NONE;
                        cur_nxt.state = ST_IDLE;
                    end
                end
                if (cur_r.kind == OP_BJ) begin
                    budget = 8'(BJUMP_CYCLES + EXT_PENALTY);
                end else if (eaExt) begin
                    budget = 8'(CJUMP_CYCLES + EXT_PENALTY);
                end
                // The decode cycle counts as the first cycle of every operation
                if (cur_r.cnt != 8'h00) begin
                    cur_nxt.cnt = cur_r.cnt + 8'h01;
                end else begin
                    cur_nxt.cnt = 8'h01;
                end
                // Commit on the last cycle; status flags never written
                if (cur_r.cnt == budget - 8'h01 && cur_r.kind == OP_CJ) begin
                    cur_nxt.state = ST_IDLE;
                    if (cjEa) begin
                        cur_nxt.areg = eaRes[15:0];
                    end
                    cur_nxt.taken = cond_true(cur_r.instr[3:0], cur_r.statusWord);
                    if (!cond_true(cur_r.instr[3:0], cur_r.statusWord)) begin
                        cur_nxt.pc = cur_r.pc + 16'h0001;
                    end else if (cjShort) begin
                        cur_nxt.pc = {4'h0, cur_r.instr[15:4]};
                    end else begin
                        cur_nxt.pc = eaRes[31:16];
                    end
                end
                if (cur_r.cnt == budget - 8'h01 && cur_r.kind == OP_BJ) begin
                    cur_nxt.state  = ST_IDLE;
                    cur_nxt.opAddr = bjAddr;
                    if (cur_r.instr[15:14] == BJ_EA_SEL) begin
                        cur_nxt.areg = eaRes[15:0];
                    end
                    // Bit numbers above 23 are treated as a set bit
                    cur_nxt.taken = cur_r.instr[4:0] <= BIT_MAX
                                    && !cur_r.operand[cur_r.instr[4:0]];
                    if (cur_nxt.taken) begin
                        cur_nxt.pc = cur_r.ext[15:0];
                    end else begin
                        cur_nxt.pc = cur_r.pc + 16'h0001;
                    end
                end
            end
            ST_TRAP: begin
                cur_nxt.cnt = cur_r.cnt + 8'h01;
                if (cur_r.cnt == 8'(TRAP_CYCLES - 1)) begin
                    cur_nxt.pc = cur_r.pc + 16'h0001;
                    if (cur_r.loopIntr && cur_r.pc == cur_r.loopEnd) begin
                        cur_nxt.loopCounter = cur_r.loopCounter - 16'h0002;
                    end
                    cur_nxt.state = cur_r.repeatOn ? ST_HOLD : ST_IDLE;
                    if (!cur_r.repeatOn) begin
                        cur_nxt.retPc = cur_r.pc;
                        cur_nxt.pc    = TRAP_VECTOR;
                        cur_nxt.statusWord[SW_IPL_LO+:2] = TRAP_IPL;
                        cur_nxt.trapPend = 1'b1;
                    end
                end
            end
            ST_HOLD: begin
                // Exception deferred until the repeat is released
                if (!cur_r.repeatOn) begin
                    cur_nxt.retPc    = cur_r.pc + 16'h0001;
                    cur_nxt.pc       = TRAP_VECTOR;
                    cur_nxt.statusWord[SW_IPL_LO+:2] = TRAP_IPL;
                    cur_nxt.trapPend = 1'b1;
                    cur_nxt.state    = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_r <= '{state: ST_IDLE, kind: OP_NONE, statusWord: SW_RESET, pc: PC_RESET,
                       bResp: RESP_OKAY, rResp: RESP_OKAY, default: '0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign s_axi_awready = !cur_r.awGot;
    assign s_axi_wready  = !cur_r.wGot;
    assign s_axi_bvalid  = cur_r.bValid;
    assign s_axi_bresp   = cur_r.bResp;
    assign s_axi_arready = !cur_r.rValid;
    assign s_axi_rvalid  = cur_r.rValid;
    assign s_axi_rdata   = cur_r.rData;
    assign s_axi_rresp   = cur_r.rResp;
    assign busy          = cur_r.state != ST_IDLE;

    // ************************************************
    // Assertions
    // ************************************************
    AST_TRAP_VECTOR: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_r.trapPend) |-> cur_r.pc == TRAP_VECTOR)
        else $error("trap did not vector");
    AST_TRAP_IPL: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_r.trapPend) |-> cur_r.statusWord[SW_IPL_LO+:2] == TRAP_IPL)
        else $error("priority mask not raised");
    AST_TRAP_LEN: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_r.state == ST_TRAP) |-> (cur_r.state == ST_TRAP) [*7] ##1 cur_r.state != ST_TRAP)
        else $error("trap length wrong");
    AST_TRAP_HOLD: assert property (@(posedge clk) disable iff (rst)
        cur_r.state == ST_HOLD && cur_r.repeatOn |=> !$rose(cur_r.trapPend))
        else $error("trap taken during repeat");
    AST_FLAGS_KEPT: assert property (@(posedge clk) disable iff (rst)
        cur_r.state != ST_IDLE |=> cur_r.statusWord[7:0] == $past(cur_r.statusWord[7:0]))
        else $error("condition flags changed");
    AST_CJ_NOT_TAKEN: assert property (@(posedge clk) disable iff (rst)
        cur_r.state == ST_EXEC && cur_nxt.state == ST_IDLE && cur_r.kind != OP_NONE
        && !cur_nxt.taken |=> cur_r.pc == $past(cur_r.pc) + 16'h0001)
        else $error("not-taken jump did not increment");
    AST_CJ_LEN: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_r.state == ST_EXEC) && cjShort |-> (cur_r.state == ST_EXEC) [*4] ##1 !busy)
        else $error("conditional jump length wrong");
    AST_BJ_LEN: assert property (@(posedge clk) disable iff (rst)
        $rose(cur_r.state == ST_EXEC) && bjForm |-> (cur_r.state == ST_EXEC) [*8] ##1 !busy)
        else $error("bit jump length wrong");
    AST_BJ_TARGET: assert property (@(posedge clk) disable iff (rst)
        cur_r.kind == OP_BJ && $fell(busy) && cur_r.taken |-> cur_r.pc == cur_r.ext[15:0])
        else $error("bit jump target wrong");
endmodule

// file: branch_trap_pkg.sv
// Package: constants, encodings and register map of the branch and trap decoder
package branch_trap_pkg;
    localparam int unsigned CLK_HZ           = 40000000;
    // Cycle budgets in oscillator clock cycles
    localparam int unsigned TRAP_CYCLES      = 8;
    localparam int unsigned CJUMP_CYCLES     = 4;
    localparam int unsigned BJUMP_CYCLES     = 6;
    localparam int unsigned EXT_PENALTY      = 2;
    localparam logic [15:0] TRAP_VECTOR      = 16'h003E;
    localparam logic [1:0]  TRAP_IPL         = 2'h3;
    localparam logic [4:0]  BIT_MAX          = 5'h17;
    // Opcode patterns
    localparam logic [23:0] OPC_TRAP         = 24'h000005;
    localparam logic [7:0]  OPC_CJ_EA_HI     = 8'h0A;
    localparam logic [3:0]  OPC_CJ_SHORT_HI  = 4'hE;
    localparam logic [7:0]  OPC_BJ_HI        = 8'h0A;
    localparam logic [1:0]  BJ_EA_SEL        = 2'h1;
    localparam logic [1:0]  BJ_AA_SEL        = 2'h0;
    localparam logic [1:0]  BJ_PP_SEL        = 2'h2;
    localparam logic [5:0]  EA_ABSOLUTE      = 6'h30;
    localparam logic [15:0] PERIPH_BASE      = 16'hFFC0;
    // Effective-address modes
    localparam logic [2:0]  EA_POSTDEC_N     = 3'h0;
    localparam logic [2:0]  EA_POSTINC_N     = 3'h1;
    localparam logic [2:0]  EA_POSTDEC       = 3'h2;
    localparam logic [2:0]  EA_POSTINC       = 3'h3;
    localparam logic [2:0]  EA_NOUPDATE      = 3'h4;
    localparam logic [2:0]  EA_INDEXED       = 3'h5;
    localparam logic [2:0]  EA_PREDEC        = 3'h7;
    // Status word bit positions
    localparam int unsigned SW_C             = 0;
    localparam int unsigned SW_V             = 1;
    localparam int unsigned SW_Z             = 2;
    localparam int unsigned SW_N             = 3;
    localparam int unsigned SW_U             = 4;
    localparam int unsigned SW_E             = 5;
    localparam int unsigned SW_L             = 6;
    localparam int unsigned SW_IPL_LO        = 8;
    // Register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_INSTR       = 8'h04;
    localparam logic [7:0]  ADDR_EXT         = 8'h08;
    localparam logic [7:0]  ADDR_STATUS      = 8'h0C;
    localparam logic [7:0]  ADDR_PC          = 8'h10;
    localparam logic [7:0]  ADDR_OPERAND     = 8'h14;
    localparam logic [7:0]  ADDR_LOOP        = 8'h18;
    localparam logic [7:0]  ADDR_RESULT      = 8'h1C;
    localparam logic [7:0]  ADDR_AREG        = 8'h20;
    localparam logic [7:0]  ADDR_OPADDR      = 8'h24;
    localparam logic [15:0] PC_RESET         = 16'h0000;
    localparam logic [23:0] SW_RESET         = 24'h000300;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_TRAP = 4'b0100,
        ST_HOLD = 4'b1000
    } exec_state_e;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_TRAP = 2'h1,
        OP_CJ   = 2'h2,
        OP_BJ   = 2'h3
    } op_kind_e;
endpackage

// file: testbench.sv
// Self-checking testbench of the branch and trap decoder, driven over its register bus
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import branch_trap_pkg::*;
    logic        clk, rst, awv, wv, bready, arv, rready;
    logic        awRdy, wRdy, bValid, arRdy, rValid, busy;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData, d;
    logic [1:0]  bResp, rResp, r;
    int          errCount, samplesChecked, cyc, busyCnt, lastCyc;
    logic [7:0]  flg [4]    = '{8'h00, 8'h0D, 8'h72, 8'h2A};
    logic [31:0] eaExp [8]  = '{32'h01FC0200, 32'h02040200, 32'h01FF0200, 32'h02010200,
                                32'h02000200, 32'h02000204, 32'h02000777, 32'h01FF01FF};
    logic [15:0] bjIns [5]  = '{16'h1580, 16'h15D7, 16'hB185, 16'h5897, 16'h0098};
    logic [23:0] bjOp [5]   = '{24'hFFFFFE, 24'h800000, 24'h000000, 24'h7FFFFF, 24'h000000};
    logic [31:0] bjExp [5]  = '{32'h00154321, 32'h00151001, 32'hFFF14321, 32'h02004321, 32'h00001001};

    branch_and_trap_decode uut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awv),
        .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wRdy),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bready), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rready), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog and count of busy cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (busy === 1'b1) busyCnt <= busyCnt + 1;
        if (cyc == 30000) begin
            errCount++;
            endOfTest();
        end
    end

    task automatic endOfTest();
        $display("Checks %0d, errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samplesChecked++;
        if (g !== e) begin
            errCount++;
            $display("ERROR t=%0t got %h expected %h", $time, g, e);
        end
    endtask

    // ****************************************
    // Register bus master
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aDone, dDone;
        @(posedge clk);
        awAddr <= a;
        wData  <= v;
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        aDone = 1'b0;
        dDone = 1'b0;
        while (!(aDone && dDone)) begin
            @(posedge clk);
            if (!aDone && awRdy === 1'b1) begin
                aDone = 1'b1;
                awv <= 1'b0;
            end
            if (!dDone && wRdy === 1'b1) begin
                dDone = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bValid !== 1'b1);
        r = bResp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        arAddr <= a;
        arv    <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arRdy !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rValid !== 1'b1);
        d = rData;
        r = rResp;
        rready <= 1'b0;
    endtask

    task automatic ex(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(d & m, e);
    endtask

    // Loads one operation and starts it; waits unless the repeat bit is set
    task automatic run(input logic [23:0] ins, ext, sw, input logic [15:0] pc, input logic [31:0] ar,
                       input logic [23:0] op, input logic [2:0] go);
        wr(ADDR_INSTR, {8'h00, ins});
        wr(ADDR_EXT, {8'h00, ext});
        wr(ADDR_STATUS, {8'h00, sw});
        wr(ADDR_PC, {16'h0000, pc});
        wr(ADDR_AREG, ar);
        wr(ADDR_OPERAND, {8'h00, op});
        lastCyc = busyCnt;
        wr(ADDR_CTRL, {29'h0, go});
        if (!go[1]) begin
            while (busy !== 1'b0) @(posedge clk);
            lastCyc = busyCnt - lastCyc;
        end
    endtask

    function automatic logic cond(input logic [3:0] c, input logic [7:0] f);
        logic b;
        case (c[2:0])
            3'h0: b = !f[SW_C];
            3'h1: b = !(f[SW_N] ^ f[SW_V]);
            3'h2: b = !f[SW_Z];
            3'h3: b = !f[SW_N];
            3'h4: b = !(f[SW_Z] | (!f[SW_U] & !f[SW_E]));
            3'h5: b = !f[SW_E];
            3'h6: b = !f[SW_L];
            default: b = !(f[SW_Z] | (f[SW_N] ^ f[SW_V]));
        endcase
        return b ^ c[3];
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        rst = 1'b1;
        {awv, wv, bready, arv, rready} = 5'h00;
        {awAddr, arAddr, wData} = 48'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ex(ADDR_STATUS, 32'h00FFFFFF, {8'h00, SW_RESET});
        ex(ADDR_PC, 32'h0000FFFF, {16'h0000, PC_RESET});
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        run(OPC_TRAP, 24'h0, 24'h00004B, 16'h0020, 32'h0, 24'h0, 3'h1);
        chk(lastCyc, TRAP_CYCLES);
        ex(ADDR_PC, 32'h0000FFFF, {16'h0000, TRAP_VECTOR});
        ex(ADDR_STATUS, 32'h00FFFFFF, 32'h0000034B);
        wr(ADDR_LOOP, 32'h000A0050);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        run(OPC_TRAP, 24'h0, 24'h0, 16'h0050, 32'h0, 24'h0, 3'h5);
        ex(ADDR_LOOP, 32'hFFFF0000, 32'h00080000);
        run(OPC_TRAP, 24'h0, 24'h0, 16'h0060, 32'h0, 24'h0, 3'h3);
        repeat (12) @(posedge clk);
        chk({31'h0, busy}, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        while (busy !== 1'b0) @(posedge clk);
        ex(ADDR_RESULT, 32'hFFFF0003, 32'h00620001);
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 16; c++) begin
                run({8'hE0, 12'hABC, c[3:0]}, 24'h0, {16'h0, flg[s]}, 16'h1234, 32'h0, 24'h0, 3'h1);
                ex(ADDR_PC, 32'h0000FFFF, cond(c[3:0], flg[s]) ? 32'h0ABC : 32'h1235);
                ex(ADDR_RESULT, 32'h00000007, cond(c[3:0], flg[s]) ? 32'h6 : 32'h2);
                ex(ADDR_STATUS, 32'h00FFFFFF, {24'h0, flg[s]});
                chk(lastCyc, CJUMP_CYCLES);
            end
        end
        for (int m = 0; m < 8; m++) begin
            for (int t = 0; t < 2; t++) begin
                run({8'h0A, 2'b11, m[2:0], 3'h0, 4'hA, t[0], 3'h0}, 24'h000777, 24'h0, 16'h1234,
                    32'h00040200, 24'h0, 3'h1);
                ex(ADDR_PC, 32'h0000FFFF, t ? 32'h1235 : {16'h0, eaExp[m][15:0]});
                ex(ADDR_AREG, 32'h0000FFFF, {16'h0, eaExp[m][31:16]});
                if (m == 6) chk(lastCyc, CJUMP_CYCLES + EXT_PENALTY);
            end
        end
        for (int i = 0; i < 5; i++) begin
            run({8'h0A, bjIns[i]}, 24'h004321, 24'h000055, 16'h1000, 32'h00040200, bjOp[i], 3'h1);
            ex(ADDR_RESULT, 32'h00000007, (bjExp[i][15:0] == 16'h4321) ? 32'h7 : 32'h3);
            ex(ADDR_PC, 32'h0000FFFF, {16'h0, bjExp[i][15:0]});
            ex(ADDR_OPADDR, 32'h0000FFFF, {16'h0, bjExp[i][31:16]});
            ex(ADDR_AREG, 32'h0000FFFF, (i == 3) ? 32'h0201 : 32'h0200);
            ex(ADDR_STATUS, 32'h00FFFFFF, 32'h00000055);
            chk(lastCyc, BJUMP_CYCLES + EXT_PENALTY);
        end
        wr(8'h40, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rd(8'h40);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        endOfTest();
    end
endmodule
